// file: hw/raw_pkg.sv
package raw_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK   = 8'h08;
  localparam logic [7:0] OFF_SEC    = 8'h0c;
  localparam logic [7:0] OFF_SUB    = 8'h10;
  localparam logic [7:0] OFF_ALARM  = 8'h14;
  localparam logic [7:0] OFF_WDOG   = 8'h18;

  // Control register bit positions.
  localparam int CTRL_WDOG_EN  = 0;
  localparam int CTRL_INT_POL  = 1;
  localparam int CTRL_ALARM_EN = 2;
  localparam int CTRL_SLEEP    = 3;
  localparam int CTRL_W        = 4;

  // Status and mask bit positions (same layout in both).
  localparam int ST_CONV_READY = 0;
  localparam int ST_ALARM      = 1;
  localparam int ST_USER_IO    = 2;
  localparam int ST_SUP_DVDD   = 3;
  localparam int ST_SUP_CPOUT  = 4;
  localparam int ST_W          = 5;

  // Reset values: only conversion-ready unmasked, active-high interrupt.
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h2;
  localparam logic [ST_W-1:0]   MASK_RST = 5'h1e;

  // Widths of the timekeeping counters.
  localparam int SEC_W   = 32;
  localparam int SUB_W   = 8;
  localparam int ALARM_W = 20;

  // Crystal and tick rates in Hz, and the divider between them.
  localparam int XTAL_HZ  = 32768;
  localparam int SUB_HZ   = 256;
  localparam int XTAL_DIV = XTAL_HZ / SUB_HZ;

  // Watchdog times in ms, counted in quarter-second crystal ticks.
  localparam int WD_QTR_MS     = 250;
  localparam int WD_TIMEOUT_MS = 500;
  localparam int WD_RESET_MS   = 250;
  localparam int WD_QTR_SUBS   = SUB_HZ * WD_QTR_MS / 1000;
  localparam logic [1:0] WD_TIMEOUT_Q = 2'(WD_TIMEOUT_MS / WD_QTR_MS);
  localparam logic [1:0] WD_RESET_Q   = 2'(WD_RESET_MS / WD_QTR_MS);

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Watchdog states, Gray coded along off, run, reset.
  typedef enum logic [1:0] {
    WD_OFF = 2'b00,
    WD_RUN = 2'b01,
    WD_RST = 2'b11
  } raw_wd_state_t;

endpackage

// file: hw/raw_top.sv
`timescale 1ns/10ps
`default_nettype none

module raw_top #(
  parameter int XTAL_DIV = raw_pkg::XTAL_DIV  // Crystal edges per subsecond tick.
) (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        xtal_i,
  input  wire logic        user_io_pin_i,
  input  wire logic        sup_dvdd_i,
  input  wire logic        sup_cpout_i,
  input  wire logic        conv_done_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic             int_o,
  output logic             wdog_rst_o,
  output logic             sleep_o
);

  // A divider below two would leave the crystal edge counter without a bit.
  if (XTAL_DIV < 2) begin : g_chk
    $error("XTAL_DIV must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.

  logic [3:0] sync1_r;   // First stage, read only by the second.
  logic [3:0] sync2_r;   // Second stage, safe to use.
  logic [3:0] prev_r;    // Delayed copy for edge detection.
  logic       xtal_rise; // One clk_i pulse per crystal period.
  logic       uio_edge;  // Either edge on the user I/O pin.
  logic       dvdd_rise; // Supply supervisor on DVDD trips.
  logic       cpout_rise; // Supply supervisor on CPOUT trips.

  // All four pins are asynchronous to clk_i, so two flops come first.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      prev_r  <= 4'h0;
    end else begin
      sync1_r <= {sup_cpout_i, sup_dvdd_i, user_io_pin_i, xtal_i};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign xtal_rise  = sync2_r[0] & ~prev_r[0];
  assign uio_edge   = sync2_r[1] ^ prev_r[1];
  assign dvdd_rise  = sync2_r[2] & ~prev_r[2];
  assign cpout_rise = sync2_r[3] & ~prev_r[3];

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave handshakes.

  logic [7:0]  wr_addr_r;   // Held write address.
  logic [31:0] wr_data_r;   // Held write data.
  logic [3:0]  wr_strb_r;   // Held byte enables.
  logic        wr_fire;     // Both halves present: perform the write.
  logic        rd_fire;     // Read address taken this cycle.
  logic        wr_known;    // Write address decodes to a register.
  logic        rd_known;    // Read address decodes to a register.
  logic [31:0] rd_val;      // Read data selected from the registers.

  // Address and data are each held once taken, in either order; the
  // response waits for both, and the readies stay low until it is taken.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= raw_pkg::RESP_OKAY;
      wr_addr_r       <= 8'h00;
      wr_data_r       <= 32'h0000_0000;
      wr_strb_r       <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        wr_addr_r       <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        wr_data_r      <= s_axi_wdata_i;
        wr_strb_r      <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_known ? raw_pkg::RESP_OKAY : raw_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  assign wr_fire = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
  assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;

  // Reads answer one cycle after the address is taken.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= raw_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= rd_val;
      s_axi_rresp_o   <= rd_known ? raw_pkg::RESP_OKAY : raw_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o  <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // Merge byte lanes of a write into an existing word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [raw_pkg::CTRL_W-1:0]  ctrl_r;     // Control bits.
  logic [raw_pkg::ST_W-1:0]    status_r;   // Sticky event flags.
  logic [raw_pkg::ST_W-1:0]    mask_r;     // One masks a flag.
  logic [raw_pkg::ALARM_W-1:0] alarm_r;    // Alarm compare seconds.
  logic [raw_pkg::SEC_W-1:0]   sec_r;      // Seconds counter.
  logic [raw_pkg::SUB_W-1:0]   sub_r;      // Subsecond counter.
  logic [raw_pkg::SEC_W-1:0]   sec_stage_r; // Seconds half of a pending set.
  logic                        stage_vld_r; // Seconds half has arrived.
  logic [raw_pkg::SUB_W-1:0]   sub_snap_r; // Subseconds caught at seconds read.
  logic [$clog2(XTAL_DIV)-1:0] div_r;      // Crystal edge divider.
  logic                        sub_tick;   // 256 Hz tick.
  logic                        qtr_tick;   // 4 Hz tick for the watchdog.
  logic                        sec_tick_r; // Seconds just advanced.
  logic                        trip;       // Alarm fires this cycle.
  logic [31:0]                 ctrl_w;     // Control after a write.
  logic                        wr_sec;     // Seconds register written.
  logic                        wr_sub;     // Subsecond register written.

  assign wr_sec = wr_fire && wr_addr_r == raw_pkg::OFF_SEC;
  assign wr_sub = wr_fire && wr_addr_r == raw_pkg::OFF_SUB;
  assign ctrl_w = merge(32'(ctrl_r), wr_data_r, wr_strb_r);

  // Address decode for both directions; reserved bits read as zero.
  always_comb begin
    wr_known = 1'b1;
    case (wr_addr_r)
      raw_pkg::OFF_CTRL, raw_pkg::OFF_STATUS, raw_pkg::OFF_MASK, raw_pkg::OFF_SEC,
      raw_pkg::OFF_SUB, raw_pkg::OFF_ALARM, raw_pkg::OFF_WDOG: wr_known = 1'b1;
      default: wr_known = 1'b0;
    endcase
    rd_known = 1'b1;
    case (s_axi_araddr_i)
      raw_pkg::OFF_CTRL:   rd_val = 32'(ctrl_r);
      raw_pkg::OFF_STATUS: rd_val = 32'(status_r);
      raw_pkg::OFF_MASK:   rd_val = 32'(mask_r);
      raw_pkg::OFF_SEC:    rd_val = sec_r;
      raw_pkg::OFF_SUB:    rd_val = 32'(sub_snap_r);
      raw_pkg::OFF_ALARM:  rd_val = 32'(alarm_r);
      raw_pkg::OFF_WDOG:   rd_val = 32'h0000_0000;
      default: begin
        rd_val   = 32'h0000_0000;
        rd_known = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Real-time clock.

  // The divider counts crystal edges, so every time below stays locked to
  // the crystal even though the logic itself runs on clk_i.
  assign sub_tick = xtal_rise && div_r == ($clog2(XTAL_DIV))'(XTAL_DIV - 1);
  assign qtr_tick = sub_tick && sub_r[5:0] == 6'(raw_pkg::WD_QTR_SUBS - 1);

  // A set takes effect only after the seconds word and then the subsecond
  // word are both written; a lone subsecond write is dropped as partial.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_r       <= '0;
      sub_r       <= '0;
      sec_r       <= '0;
      sec_tick_r  <= 1'b0;
      sec_stage_r <= '0;
      stage_vld_r <= 1'b0;
    end else begin
      sec_tick_r <= 1'b0;
      if (wr_sec) begin
        sec_stage_r <= merge(sec_stage_r, wr_data_r, wr_strb_r);
        stage_vld_r <= 1'b1;
      end else if (wr_sub) begin
        stage_vld_r <= 1'b0;
      end
      if (wr_sub && stage_vld_r) begin
        sec_r <= sec_stage_r;
        sub_r <= wr_data_r[raw_pkg::SUB_W-1:0];
        div_r <= '0;
      end else if (xtal_rise) begin
        div_r <= sub_tick ? '0 : div_r + 1'b1;
        if (sub_tick) begin
          sub_r <= sub_r + 1'b1;
          if (&sub_r) begin
            sec_r      <= sec_r + 1'b1;
            sec_tick_r <= 1'b1;
          end
        end
      end
    end
  end

  // Reading seconds freezes the subseconds so both halves match.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sub_snap_r <= '0;
    end else if (rd_fire && s_axi_araddr_i == raw_pkg::OFF_SEC) begin
      sub_snap_r <= sub_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm and control.

  // Compare only once per new second so a match fires exactly once.
  assign trip = sec_tick_r && ctrl_r[raw_pkg::CTRL_ALARM_EN] &&
                sec_r[raw_pkg::ALARM_W-1:0] == alarm_r;

  // The alarm holds a 20-bit seconds value, about 12 days of range.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      alarm_r <= '0;
    end else if (wr_fire && wr_addr_r == raw_pkg::OFF_ALARM) begin
      alarm_r <= (raw_pkg::ALARM_W)'(merge(32'(alarm_r), wr_data_r, wr_strb_r));
    end
  end

  // The trip wins over a simultaneous software write to enable or sleep.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r <= raw_pkg::CTRL_RST;
    end else begin
      if (wr_fire && wr_addr_r == raw_pkg::OFF_CTRL) begin
        ctrl_r <= ctrl_w[raw_pkg::CTRL_W-1:0];
      end
      if (trip) begin
        ctrl_r[raw_pkg::CTRL_ALARM_EN] <= 1'b0;
        ctrl_r[raw_pkg::CTRL_SLEEP]    <= 1'b0;
      end
    end
  end

  assign sleep_o = ctrl_r[raw_pkg::CTRL_SLEEP];

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and output.

  logic [raw_pkg::ST_W-1:0] st_set; // Events arriving this cycle.
  logic [raw_pkg::ST_W-1:0] st_clr; // Write-one-to-clear bits.

  assign st_set = {cpout_rise, dvdd_rise, uio_edge, trip, conv_done_i};
  assign st_clr = (wr_fire && wr_addr_r == raw_pkg::OFF_STATUS) ?
                  wr_data_r[raw_pkg::ST_W-1:0] & {raw_pkg::ST_W{wr_strb_r[0]}} : '0;

  // An event in the cycle of its clear is kept: set wins.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~st_clr) | st_set;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mask_r <= raw_pkg::MASK_RST;
    end else if (wr_fire && wr_addr_r == raw_pkg::OFF_MASK && wr_strb_r[0]) begin
      mask_r <= wr_data_r[raw_pkg::ST_W-1:0];
    end
  end

  // Registered output adds one cycle of latency but keeps the pin glitch free.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      int_o <= 1'b0;
    end else begin
      int_o <= (|(status_r & ~mask_r)) ? ctrl_r[raw_pkg::CTRL_INT_POL] :
               ~ctrl_r[raw_pkg::CTRL_INT_POL];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog.

  raw_pkg::raw_wd_state_t wd_state_r; // Watchdog state.
  logic [1:0]             wd_cnt_r;   // Quarter ticks since service.
  logic                   wd_svc;     // Service write seen.

  assign wd_svc = wr_fire && wr_addr_r == raw_pkg::OFF_WDOG;

  // Counting whole quarter ticks means the service phase is unknown to the
  // counter: the timeout falls between two and three quarters after it.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wd_state_r <= raw_pkg::WD_OFF;
      wd_cnt_r   <= 2'h0;
      wdog_rst_o <= 1'b0;
    end else if (!ctrl_r[raw_pkg::CTRL_WDOG_EN]) begin
      wd_state_r <= raw_pkg::WD_OFF;
      wd_cnt_r   <= 2'h0;
      wdog_rst_o <= 1'b0;
    end else begin
      case (wd_state_r)
        raw_pkg::WD_OFF: begin
          wd_state_r <= raw_pkg::WD_RUN;
          wd_cnt_r   <= 2'h0;
        end
        raw_pkg::WD_RUN: begin
          if (wd_svc) begin
            wd_cnt_r <= 2'h0;
          end else if (qtr_tick) begin
            if (wd_cnt_r == raw_pkg::WD_TIMEOUT_Q) begin
              wd_state_r <= raw_pkg::WD_RST;
              wd_cnt_r   <= 2'h0;
              wdog_rst_o <= 1'b1;
            end else begin
              wd_cnt_r <= wd_cnt_r + 2'h1;
            end
          end
        end
        raw_pkg::WD_RST: begin
          if (qtr_tick) begin
            if (wd_cnt_r == raw_pkg::WD_RESET_Q - 2'h1) begin
              wd_state_r <= raw_pkg::WD_RUN;
              wd_cnt_r   <= 2'h0;
              wdog_rst_o <= 1'b0;
            end else begin
              wd_cnt_r <= wd_cnt_r + 2'h1;
            end
          end
        end
        default: begin
          wd_state_r <= raw_pkg::WD_OFF;
          wd_cnt_r   <= 2'h0;
          wdog_rst_o <= 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// file: dv/raw_mcu_model.sv
`timescale 1ns/10ps
`default_nettype none

// Host controller model: it only listens to the interrupt and reset pins.
module raw_mcu_model (
  input  wire logic        clk_i,      // Controller clock, shared with the block.
  input  wire logic        arst_n_i,   // Power-on reset of the controller.
  input  wire logic        irq_pin_i,  // Interrupt pin as driven by the block.
  input  wire logic        rst_pin_i,  // Watchdog reset pin, active high.
  input  wire logic        pol_i,      // Level that the controller reads as asserted.
  output logic             irq_seen_o, // High while an interrupt is pending.
  output logic [15:0]      rst_len_o,  // Cycles of the last watchdog reset pulse.
  output logic [7:0]       rst_cnt_o   // Watchdog reset pulses seen so far.
);
  logic [15:0] run_r; // Cycles of the pulse under way.

  // The pin is decoded through the polarity that software chose.
  assign irq_seen_o = (irq_pin_i === pol_i);

  ////////////////////////////////////////////////////////////////////////////
  // A pulse is closed at its first low sample, so a pulse cut short still counts.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_r     <= 16'h0;
      rst_len_o <= 16'h0;
      rst_cnt_o <= 8'h0;
    end else if (rst_pin_i) begin
      run_r <= run_r + 16'h1;
    end else if (run_r != 16'h0) begin
      rst_len_o <= run_r;
      rst_cnt_o <= rst_cnt_o + 8'h1;
      run_r     <= 16'h0;
    end
  end
endmodule

`default_nettype wire

// file: dv/raw_top_chk.sv
`timescale 1ns/10ps
`default_nettype none

module raw_top_chk #(
  parameter int XTAL_DIV = raw_pkg::XTAL_DIV // Crystal edges per subsecond tick.
) (
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic        xtal_i,
  input wire logic [7:0]  s_axi_awaddr_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic [7:0]  s_axi_araddr_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        int_o,
  input wire logic        wdog_rst_o,
  input wire logic        sleep_o
);
  localparam int QTR = 64 * XTAL_DIV; // Crystal edges in one watchdog quarter.
  logic        xtal_r; // Crystal level one cycle back.
  logic        en_r;   // Watchdog enable as last written.
  logic [15:0] on_r;   // Crystal edges while the reset pin is high.
  logic [15:0] idle_r; // Crystal edges since the last service, control write or watchdog reset pulse.
  wire logic   xedge = xtal_i & ~xtal_r;
  wire logic   wtake = s_axi_awvalid_i & s_axi_awready_o & s_axi_wvalid_i & s_axi_wready_o;
  wire logic   ctrl_w = wtake & (s_axi_awaddr_i == raw_pkg::OFF_CTRL);
  wire logic   svc = ctrl_w | (wtake & (s_axi_awaddr_i == raw_pkg::OFF_WDOG));

  ////////////////////////////////////////////////////////////////////////////
  // Crystal time is counted here, since only crystal edges time the watchdog.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      xtal_r <= 1'b0;
      en_r   <= 1'b0;
      on_r   <= 16'h0;
      idle_r <= 16'h0;
    end else begin
      xtal_r <= xtal_i;
      en_r   <= ctrl_w ? s_axi_wdata_i[0] : en_r;
      on_r   <= wdog_rst_o ? on_r + 16'(xedge) : 16'h0;
      idle_r <= (svc | wdog_rst_o) ? 16'h0 : idle_r + 16'(xedge);
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  ////////////////////////////////////////////////////////////////////////////
  a_reset_idle: assert property (
    $rose(arst_n_i) |-> !int_o && !wdog_rst_o && !sleep_o)
    else $error("Outputs not idle after reset release.");
  a_write_resp: assert property (
    wtake |-> ##2 s_axi_bvalid_o)
    else $error("Write response not two cycles after the take.");
  a_aw_block: assert property (
    s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o && !s_axi_bvalid_o)
    else $error("Write address ready not dropped after take.");
  a_read_resp: assert property (
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("Read data not one cycle after the take.");
  a_bad_addr: assert property (
    s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i > 8'h18
    |=> s_axi_rresp_o == raw_pkg::RESP_SLVERR && s_axi_rdata_o == 32'h0)
    else $error("Unmapped read not refused.");
  a_wd_len: assert property (
    wdog_rst_o |-> on_r <= 16'(QTR + 1))
    else $error("Watchdog reset longer than a quarter.");
  a_wd_early: assert property (
    $rose(wdog_rst_o) |-> idle_r >= 16'(2 * QTR - 2))
    else $error("Watchdog tripped before two quarters.");
  a_wd_late: assert property (
    en_r && !wdog_rst_o |-> idle_r <= 16'(3 * QTR + 2))
    else $error("Watchdog failed to trip by three quarters.");
  a_wd_stop: assert property (
    ctrl_w && !s_axi_wdata_i[0] |-> ##4 !wdog_rst_o [*8])
    else $error("Watchdog reset not stopped after disable.");
endmodule

bind raw_top raw_top_chk #(.XTAL_DIV(XTAL_DIV)) u_raw_top_chk (
  .clk_i, .arst_n_i, .xtal_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
  .s_axi_wdata_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_araddr_i,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
  .int_o, .wdog_rst_o, .sleep_o);

`default_nettype wire

// file: dv/tb_raw_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_raw_top;
  localparam int DIV = 2; // Short divider: one second lasts 4096 cycles.
  logic        clk_i = 1'b0, arst_n = 1'b0, pol = 1'b1;
  logic        conv = 1'b0, uio = 1'b0, dvdd = 1'b0, cpo = 1'b0;
  logic [2:0]  xc = 3'h0; // Crystal phase; the crystal runs at an eighth of the clock.
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, d, s1;
  logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  wire logic   awr, wrdy, bv, arr, rv, irq, wdr, slp, irq_seen;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [15:0] rlen;
  wire logic [7:0]  rcnt;
  int          fails = 0, num_checks = 0, cyc = 0, n;

  raw_top #(.XTAL_DIV(DIV)) u_raw_top (
    .clk_i(clk_i), .arst_n_i(arst_n), .xtal_i(xc[2]), .user_io_pin_i(uio), .sup_dvdd_i(dvdd),
    .sup_cpout_i(cpo), .conv_done_i(conv), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrdy), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rready), .int_o(irq),
    .wdog_rst_o(wdr), .sleep_o(slp));

  raw_mcu_model u_raw_mcu_model (
    .clk_i(clk_i), .arst_n_i(arst_n), .irq_pin_i(irq), .rst_pin_i(wdr), .pol_i(pol),
    .irq_seen_o(irq_seen), .rst_len_o(rlen), .rst_cnt_o(rcnt));

  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) xc <= xc + 3'h1;

  ////////////////////////////////////////////////////////////////////////////
  // One compare point, so every mismatch is counted the same way.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Address and data go out together; bready waits up front so no cycle is lost.
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = raw_pkg::RESP_OKAY);
    @(posedge clk_i);
    awaddr <= a;
    wdata  <= v;
    awv    <= 1'b1;
    wv     <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (!(bv && bready));
    bready <= 1'b0;
    chk(32'(bresp), 32'(er), "bresp");
  endtask

  // Read data is taken at the very edge where rvalid is seen.
  task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er = raw_pkg::RESP_OKAY);
    @(posedge clk_i);
    araddr <= a;
    arv    <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arv && arr) arv <= 1'b0;
    end while (!(rv && rready));
    v = rdata;
    rready <= 1'b0;
    chk(32'(rresp), 32'(er), "rresp");
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a, d);
    chk(d, e, nm);
  endtask

  task automatic results;
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // A hang is cut off well after the longest expected run of about 17000 cycles.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_i);
    arst_n <= 1'b1;
    @(posedge clk_i);
    chk(32'(irq), 32'h0, "int_reset");
    rdc(raw_pkg::OFF_CTRL, 32'h2, "ctrl_reset");
    rdc(raw_pkg::OFF_MASK, 32'h1e, "mask_reset");
    // A finished conversion must reach the pin, then be masked, inverted and cleared.
    @(posedge clk_i);
    conv <= 1'b1;
    @(posedge clk_i);
    conv <= 1'b0;
    repeat (3) @(posedge clk_i);
    rdc(raw_pkg::OFF_STATUS, 32'h1, "status_conv");
    chk(32'(irq_seen), 32'h1, "irq_conv");
    wr(raw_pkg::OFF_MASK, 32'h1f);
    repeat (3) @(posedge clk_i);
    chk(32'(irq), 32'h0, "irq_masked");
    wr(raw_pkg::OFF_CTRL, 32'h0);
    pol <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(32'(irq), 32'h1, "irq_idle_low");
    wr(raw_pkg::OFF_MASK, 32'h1e);
    repeat (3) @(posedge clk_i);
    chk(32'(irq_seen), 32'h1, "irq_low");
    wr(raw_pkg::OFF_STATUS, 32'h1);
    repeat (3) @(posedge clk_i);
    chk(32'(irq_seen), 32'h0, "irq_cleared");
    wr(raw_pkg::OFF_CTRL, 32'h2);
    pol <= 1'b1;
    // Pin edges, both directions on the user pin.
    uio  <= 1'b1;
    dvdd <= 1'b1;
    cpo  <= 1'b1;
    repeat (6) @(posedge clk_i);
    rdc(raw_pkg::OFF_STATUS, 32'h1c, "status_rise");
    wr(raw_pkg::OFF_STATUS, 32'h1c);
    uio <= 1'b0;
    repeat (6) @(posedge clk_i);
    rdc(raw_pkg::OFF_STATUS, 32'h4, "status_fall");
    wr(raw_pkg::OFF_STATUS, 32'h4);
    // Unmapped place: refused and without effect.
    rd(8'h1c, d, raw_pkg::RESP_SLVERR);
    chk(d, 32'h0, "rdata_bad");
    wr(8'h1c, 32'hffffffff, raw_pkg::RESP_SLVERR);
    // Set the time just before a carry; the alarm matches but is not enabled.
    wr(raw_pkg::OFF_SEC, 32'h12345);
    wr(raw_pkg::OFF_SUB, 32'hf0);
    wr(raw_pkg::OFF_ALARM, 32'h12346);
    repeat (600) @(posedge clk_i);
    rdc(raw_pkg::OFF_SEC, 32'h12346, "sec_carry");
    rd(raw_pkg::OFF_SUB, s1);
    rdc(raw_pkg::OFF_STATUS, 32'h0, "alarm_off");
    repeat (160) @(posedge clk_i);
    rd(raw_pkg::OFF_SEC, d);
    rd(raw_pkg::OFF_SUB, d);
    chk(32'(d - s1 >= 32'd10 && d - s1 <= 32'd11), 32'h1, "sub_rate");
    s1 = d;
    wr(raw_pkg::OFF_SUB, 32'h0);
    rd(raw_pkg::OFF_SEC, d);
    rd(raw_pkg::OFF_SUB, d);
    chk(32'(d >= s1), 32'h1, "sub_alone");
    // Enabled alarm in sleep: it must wake, disarm itself and flag.
    wr(raw_pkg::OFF_MASK, 32'h1c);
    wr(raw_pkg::OFF_ALARM, 32'h12347);
    wr(raw_pkg::OFF_CTRL, 32'he);
    repeat (3) @(posedge clk_i);
    chk(32'(slp), 32'h1, "sleep_on");
    n = 0;
    while (slp !== 1'b0 && n < 6000) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(slp), 32'h0, "wake");
    rdc(raw_pkg::OFF_CTRL, 32'h2, "alarm_disarm");
    rdc(raw_pkg::OFF_STATUS, 32'h2, "alarm_flag");
    chk(32'(irq_seen), 32'h1, "irq_alarm");
    wr(raw_pkg::OFF_STATUS, 32'h2);
    wr(raw_pkg::OFF_MASK, 32'h1e);
    // Serviced watchdog stays quiet; a missed service gives one timed pulse.
    wr(raw_pkg::OFF_CTRL, 32'h3);
    repeat (3) begin
      repeat (1500) @(posedge clk_i);
      wr(raw_pkg::OFF_WDOG, 32'h0);
    end
    chk(32'(rcnt), 32'h0, "wd_serviced");
    n = 0;
    while (wdr !== 1'b1 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(n >= 2040 && n <= 3080), 32'h1, "wd_window");
    n = 0;
    while (wdr !== 1'b0 && n < 1200) begin
      @(posedge clk_i);
      n++;
    end
    repeat (2) @(posedge clk_i);
    chk(32'(rlen), 32'(64 * DIV * 8), "wd_len");
    wr(raw_pkg::OFF_CTRL, 32'h2);
    repeat (4200) @(posedge clk_i);
    chk(32'(rcnt), 32'h1, "wd_stopped");
    results();
  end
endmodule

`default_nettype wire
